// File: inc/scs_pkg.sv
// constants for the system clock selector
package scs_pkg;
  // internal oscillator rate and the cycle figures derived from it
  localparam int unsigned OSC_FREQ_MHZ  = 20;
  localparam int unsigned CLK_PERIOD_NS = 1000 / OSC_FREQ_MHZ;

  // register addresses on the internal register port
  localparam logic [7:0] ADDR_CLOCK_SOURCE_SELECT = 8'h32;
  localparam logic [7:0] ADDR_OSCILLATOR_CONTROL  = 8'h33;

  // clock source choice field
  localparam int unsigned SEL_W   = 3;
  localparam int unsigned SEL_LSB = 0;

  // oscillator control field positions
  localparam int unsigned OSC_RESERVED_BIT = 3;
  localparam int unsigned OSC_FORCE_ON_BIT = 2;
  localparam int unsigned OSC_POWER_BIT    = 1;
  localparam int unsigned OSC_GATING_BIT   = 0;

  // reset values
  localparam logic [7:0] CLOCK_SOURCE_SELECT_RST = 8'h00;
  localparam logic [7:0] OSCILLATOR_CONTROL_RST  = 8'h06;

  // source codes of the choice field
  localparam logic [2:0] SRC_DIV1 = 3'h0;
  localparam logic [2:0] SRC_DIV2 = 3'h1;
  localparam logic [2:0] SRC_DIV4 = 3'h2;
  localparam logic [2:0] SRC_DIV8 = 3'h3;
  localparam logic [2:0] SRC_EXT  = 3'h4;
  localparam logic [2:0] SRC_RTC  = 3'h5;
endpackage

// File: logic/scs_edge_det.sv
// edge detector for a clock pin sampled on the system clock
`timescale 1ns/1ns
`default_nettype none
module scs_edge_det
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // sampled level
  input  wire logic i_sig,
  // edge pulses
  output logic      o_rise,
  output logic      o_fall
);
  logic prev_q;
  logic prev_d;

  // remember the last sample
  always_comb
  begin
    prev_d = i_sig;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      prev_q <= 1'b0;
    else
      prev_q <= prev_d;
  end

  // one-cycle pulses on a change of level
  assign o_rise = i_sig & ~prev_q;
  assign o_fall = ~i_sig & prev_q;
endmodule
`default_nettype wire

// File: logic/scs_clock_select.sv
// system clock source selection and internal oscillator control
//
// Notes on behaviour
// RULE1: after reset the system clock comes from the undivided 20 MHz internal oscillator.
// RULE2: choice codes 000 to 011 give the internal oscillator divided by 1, 2, 4 or 8.
// RULE3: code 100 takes the external clock pin and code 101 the real-time clock oscillator.
// RULE4: codes 110 and 111 are reserved and software must not write them.
// RULE5: while the external clock override is set the external clock pin is used.
// RULE6: bits 7 to 3 of the clock source select register read zero and ignore writes.
// RULE7: the clock source select register sits at 0x32 in bits 2 to 0 and resets to zero.
// RULE8: oscillator control holds reserved, force-on, power-enable and pin-gating at 3..0.
// RULE9: force-on keeps the oscillator output running; clearing it gates the output only.
// RULE10: clearing power-enable removes oscillator power; setting it allows power.
// RULE11: with pin gating on and force-on off, a pin rise stops and a fall restarts it.
// RULE12: software hands control to the pin by setting both bits, then clearing force-on.
// RULE13: switching sources never shortens a high or low phase of the system clock.
`timescale 1ns/1ns
`default_nettype none
module scs_clock_select
#(
  parameter int unsigned DIV_BITS = 3
)
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // internal register port
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  // clock pins and override from the misc control register
  input  wire logic       i_ext_clk,
  input  wire logic       i_rtc_clk,
  input  wire logic       i_ext_clock_override,
  // system clock as one enable pulse per period, and the code of the source in use
  output logic            o_sys_tick,
  output logic      [2:0] o_active_source,
  // oscillator controls
  output logic            o_osc_power,
  output logic            o_osc_clk_open
);
  // divider must reach divide by 8
  if (DIV_BITS < 3)
  begin : g_bad_div
    $error("DIV_BITS must be at least 3");
  end

  logic [2:0]          clock_source_choice_q;
  logic [2:0]          clock_source_choice_d;
  logic                osc_force_on_q;
  logic                osc_force_on_d;
  logic                osc_power_enable_q;
  logic                osc_power_enable_d;
  logic                osc_pin_gating_enable_q;
  logic                osc_pin_gating_enable_d;
  logic [7:0]          rdata_q;
  logic [7:0]          rdata_d;
  logic                stopped_q;
  logic                stopped_d;
  logic [2:0]          active_q;
  logic [2:0]          active_d;
  logic [DIV_BITS-1:0] div_cnt_q;
  logic [DIV_BITS-1:0] div_cnt_d;
  logic                tick_q;
  logic                tick_d;
  logic                ext_rise;
  logic                ext_fall;
  logic                rtc_rise;
  logic                osc_open;
  logic [2:0]          eff_sel;
  logic                sel_valid;
  logic                cur_tick;
  logic                do_switch;

  // pin edges, sampled as synchronous inputs
  scs_edge_det u_ext_edge
  (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_sig   (i_ext_clk),
    .o_rise  (ext_rise),
    .o_fall  (ext_fall)
  );

  scs_edge_det u_rtc_edge
  (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_sig   (i_rtc_clk),
    .o_rise  (rtc_rise),
    .o_fall  ()
  );

  // register writes and read data
  always_comb
  begin
    clock_source_choice_d   = clock_source_choice_q;
    osc_force_on_d          = osc_force_on_q;
    osc_power_enable_d      = osc_power_enable_q;
    osc_pin_gating_enable_d = osc_pin_gating_enable_q;
    rdata_d                 = rdata_q;
    if (i_reg_wr && i_reg_addr == scs_pkg::ADDR_CLOCK_SOURCE_SELECT)
    begin
      // upper bits are dropped on write
      clock_source_choice_d = i_reg_wdata[scs_pkg::SEL_LSB +: scs_pkg::SEL_W]; // RULE7 RULE6
    end
    else if (i_reg_wr && i_reg_addr == scs_pkg::ADDR_OSCILLATOR_CONTROL)
    begin
      osc_force_on_d          = i_reg_wdata[scs_pkg::OSC_FORCE_ON_BIT]; // RULE8
      osc_power_enable_d      = i_reg_wdata[scs_pkg::OSC_POWER_BIT];
      osc_pin_gating_enable_d = i_reg_wdata[scs_pkg::OSC_GATING_BIT];
    end
    if (i_reg_rd)
    begin
      if (i_reg_addr == scs_pkg::ADDR_CLOCK_SOURCE_SELECT)
        rdata_d = {5'h00, clock_source_choice_q}; // RULE6
      else if (i_reg_addr == scs_pkg::ADDR_OSCILLATOR_CONTROL)
        rdata_d = {4'h0, 1'b0, osc_force_on_q, osc_power_enable_q,
                   osc_pin_gating_enable_q}; // RULE8
      else
        rdata_d = 8'h00;
    end
  end

  // register state; reset values give the undivided oscillator
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      clock_source_choice_q   <= scs_pkg::CLOCK_SOURCE_SELECT_RST[2:0]; // RULE1 RULE7
      osc_force_on_q          <= scs_pkg::OSCILLATOR_CONTROL_RST[scs_pkg::OSC_FORCE_ON_BIT];
      osc_power_enable_q      <= scs_pkg::OSCILLATOR_CONTROL_RST[scs_pkg::OSC_POWER_BIT];
      osc_pin_gating_enable_q <= scs_pkg::OSCILLATOR_CONTROL_RST[scs_pkg::OSC_GATING_BIT];
      rdata_q                 <= 8'h00;
    end
    else
    begin
      clock_source_choice_q   <= clock_source_choice_d;
      osc_force_on_q          <= osc_force_on_d;
      osc_power_enable_q      <= osc_power_enable_d;
      osc_pin_gating_enable_q <= osc_pin_gating_enable_d;
      rdata_q                 <= rdata_d;
    end
  end

  // oscillator gate: power-enable and either force-on, or pin gating while the pin has not stopped it
  assign osc_open = osc_power_enable_q
                  & (osc_force_on_q | (osc_pin_gating_enable_q & ~stopped_q)); // RULE9 RULE10

  // pin rise stops the oscillator, the next fall restarts it
  always_comb
  begin
    stopped_d = 1'b0;
    if (osc_pin_gating_enable_q && !osc_force_on_q)
    begin
      if (ext_rise)
        stopped_d = 1'b1; // RULE11
      else if (ext_fall)
        stopped_d = 1'b0; // RULE11
      else
        stopped_d = stopped_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      stopped_q <= 1'b0;
    else
      stopped_q <= stopped_d;
  end

  // override beats the choice field; reserved codes are never taken up
  assign eff_sel   = i_ext_clock_override ? scs_pkg::SRC_EXT : clock_source_choice_q; // RULE5
  assign sel_valid = eff_sel <= scs_pkg::SRC_RTC; // RULE4

  // end of one period of the running source
  always_comb
  begin
    case (active_q)
      scs_pkg::SRC_DIV1: cur_tick = osc_open; // RULE2
      scs_pkg::SRC_DIV2: cur_tick = osc_open & div_cnt_q[0];
      scs_pkg::SRC_DIV4: cur_tick = osc_open & (&div_cnt_q[1:0]);
      scs_pkg::SRC_DIV8: cur_tick = osc_open & (&div_cnt_q[2:0]);
      scs_pkg::SRC_EXT:  cur_tick = ext_rise; // RULE3
      scs_pkg::SRC_RTC:  cur_tick = rtc_rise; // RULE3
      default:           cur_tick = 1'b0;
    endcase
  end

  // change source only when the old one completes a period, and restart the
  // divider so the new one begins a full period; a dead source holds the switch
  assign do_switch = sel_valid & (eff_sel != active_q) & cur_tick; // RULE13

  always_comb
  begin
    active_d  = do_switch ? eff_sel : active_q;
    tick_d    = cur_tick;
    if (do_switch)
      div_cnt_d = '0; // RULE13
    else if (osc_open)
      div_cnt_d = div_cnt_q + 1'b1;
    else
      div_cnt_d = div_cnt_q;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      active_q  <= scs_pkg::SRC_DIV1; // RULE1
      div_cnt_q <= '0;
      tick_q    <= 1'b0;
    end
    else
    begin
      active_q  <= active_d;
      div_cnt_q <= div_cnt_d;
      tick_q    <= tick_d;
    end
  end

  // outputs
  assign o_reg_rdata     = rdata_q;
  assign o_sys_tick      = tick_q;
  assign o_active_source = active_q;
  assign o_osc_power     = osc_power_enable_q; // RULE10
  assign o_osc_clk_open  = osc_open;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_div1_every_cycle: assert property ( // RULE2
    (active_q == scs_pkg::SRC_DIV1 && osc_open) |=> o_sys_tick)
    else $error("divide by 1 missed a tick");

  a_div8_period: assert property ( // RULE2
    (active_q == scs_pkg::SRC_DIV8 && cur_tick) |-> div_cnt_q[2:0] == 3'h7)
    else $error("divide by 8 ticked early");

  // judged from the pin itself, so a broken edge detector is caught as well
  a_ext_route: assert property ( // RULE3
    active_q == scs_pkg::SRC_EXT |=> o_sys_tick == ($past(i_ext_clk) && !$past(i_ext_clk, 2)))
    else $error("external clock not routed");

  a_rtc_route: assert property ( // RULE3
    active_q == scs_pkg::SRC_RTC |=> o_sys_tick == $past(rtc_rise))
    else $error("rtc clock not routed");

  a_reserved_hold: assert property ( // RULE4
    !sel_valid |=> $stable(active_q))
    else $error("reserved code taken up");

  a_override_ext: assert property ( // RULE5
    (i_ext_clock_override && cur_tick) |=> active_q == scs_pkg::SRC_EXT)
    else $error("override ignored");

  a_sel_upper_zero: assert property ( // RULE6
    (i_reg_rd && i_reg_addr == scs_pkg::ADDR_CLOCK_SOURCE_SELECT) |=> o_reg_rdata[7:3] == 5'h00)
    else $error("upper select bits not zero");

  a_sel_write: assert property ( // RULE7
    (i_reg_wr && i_reg_addr == scs_pkg::ADDR_CLOCK_SOURCE_SELECT)
      |=> clock_source_choice_q == $past(i_reg_wdata[2:0]))
    else $error("select write lost");

  a_gate_closed: assert property ( // RULE9
    (!osc_force_on_q && !osc_pin_gating_enable_q) |-> !o_osc_clk_open)
    else $error("oscillator output not gated");

  a_power_off: assert property ( // RULE10
    !osc_power_enable_q |-> (!o_osc_power && !o_osc_clk_open))
    else $error("oscillator powered while disabled");

  a_pin_stop: assert property ( // RULE11
    (osc_pin_gating_enable_q && !osc_force_on_q && ext_rise && !i_reg_wr)
      |=> !o_osc_clk_open)
    else $error("pin rise did not stop oscillator");

  a_switch_on_tick: assert property ( // RULE13
    $changed(active_q) |-> $past(cur_tick))
    else $error("source changed mid period");
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the system clock selector
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        i_clk;
  logic        i_rst_b;
  logic [7:0]  i_reg_addr;
  logic        i_reg_wr;
  logic        i_reg_rd;
  logic [7:0]  i_reg_wdata;
  logic [7:0]  o_reg_rdata;
  logic        i_ext_clk = 1'b0;
  logic        i_rtc_clk = 1'b0;
  logic        i_ext_clock_override;
  logic        o_sys_tick;
  logic [2:0]  o_active_source;
  logic        o_osc_power;
  logic        o_osc_clk_open;
  logic        ext_run;
  logic        ext_man;
  logic [31:0] r;
  logic [7:0]  ua;
  int          err_total;
  int          total_checks;
  int          seed;
  int          sel_m;
  int          osc_m;
  int          pin_cnt = 0;
  int          div_tab [6] = '{1, 2, 4, 8, 6, 10};
  int          ord [6]     = '{3, 1, 5, 0, 4, 2};

  scs_clock_select #(.DIV_BITS(3)) i_dut
  (
    .i_clk                (i_clk),
    .i_rst_b              (i_rst_b),
    .i_reg_addr           (i_reg_addr),
    .i_reg_wr             (i_reg_wr),
    .i_reg_rd             (i_reg_rd),
    .i_reg_wdata          (i_reg_wdata),
    .o_reg_rdata          (o_reg_rdata),
    .i_ext_clk            (i_ext_clk),
    .i_rtc_clk            (i_rtc_clk),
    .i_ext_clock_override (i_ext_clock_override),
    .o_sys_tick           (o_sys_tick),
    .o_active_source      (o_active_source),
    .o_osc_power          (o_osc_power),
    .o_osc_clk_open       (o_osc_clk_open)
  );

  // 50 ns period
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // pin clocks: ext every 6 cycles, rtc every 10; ext can be held by hand
  always @(posedge i_clk)
  begin
    pin_cnt   <= (pin_cnt + 1) % 30;
    i_ext_clk <= ext_run ? ((pin_cnt % 6) < 3) : ext_man;
    i_rtc_clk <= (pin_cnt % 10) < 5;
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one edge of the clock, sampled once updates have landed
  task automatic step(inout int n);
    @(posedge i_clk);
    #1;
    n++;
    if (n >= 200)
    begin
      err_total++;
      print_verdict();
    end
  endtask

  // model follows every write; only the low three bits are kept
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_clk);
    i_reg_wr    <= 1'b0;
    if (a == scs_pkg::ADDR_CLOCK_SOURCE_SELECT) sel_m = int'(d[2:0]);
    if (a == scs_pkg::ADDR_OSCILLATOR_CONTROL) osc_m = int'(d[2:0]);
  endtask

  task automatic read_check(input logic [7:0] a);
    logic [7:0] exp;
    exp = 8'h00;
    if (a == scs_pkg::ADDR_CLOCK_SOURCE_SELECT) exp = sel_m[7:0];
    if (a == scs_pkg::ADDR_OSCILLATOR_CONTROL) exp = osc_m[7:0];
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_clk);
    i_reg_rd   <= 1'b0;
    #1;
    check("read data", o_reg_rdata, exp);
  endtask

  task automatic wait_tick(output int n);
    n = 0;
    do step(n); while (o_sys_tick !== 1'b1);
  endtask

  // switch is taken at a period end, so wait for the source, then time one period
  task automatic run_source(input int code);
    int n;
    n = 0;
    while (o_active_source !== code[2:0]) step(n);
    check("active source", {5'h00, o_active_source}, code[7:0]);
    wait_tick(n);
    wait_tick(n);
    check("tick period", n[7:0], div_tab[code][7:0]);
  endtask

  task automatic wait_open(input logic exp);
    int n;
    n = 0;
    while (o_osc_clk_open !== exp) step(n);
    check("osc clock open", {7'h00, o_osc_clk_open}, {7'h00, exp});
  endtask

  initial
  begin
    i_rst_b = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_wdata = 8'h00;
    i_ext_clock_override = 1'b0;
    ext_run = 1'b1;
    ext_man = 1'b0;
    err_total = 0;
    total_checks = 0;
    seed = 65;
    sel_m = 0;
    osc_m = 6;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    run_source(0);
    read_check(scs_pkg::ADDR_CLOCK_SOURCE_SELECT);
    read_check(scs_pkg::ADDR_OSCILLATOR_CONTROL);
    check("osc power", {7'h00, o_osc_power}, 8'h01);
    // every legal code, random junk in the unused bits
    for (int i = 0; i < 6; i++)
    begin
      r = $random(seed);
      reg_write(scs_pkg::ADDR_CLOCK_SOURCE_SELECT, {r[7:3], ord[i][2:0]});
      read_check(scs_pkg::ADDR_CLOCK_SOURCE_SELECT);
      run_source(ord[i]);
    end
    // unmapped place: reads zero and a write there leaves the select register unchanged
    r = $random(seed);
    ua = (r[7:1] == 7'h19) ? 8'h35 : r[7:0];
    reg_write(ua, 8'hFF);
    read_check(ua);
    read_check(scs_pkg::ADDR_CLOCK_SOURCE_SELECT);
    // override wins over the divide-by-4 choice, then hands it back
    @(posedge i_clk);
    i_ext_clock_override <= 1'b1;
    run_source(4);
    @(posedge i_clk);
    i_ext_clock_override <= 1'b0;
    run_source(2);
    // hand the oscillator to the pin the documented way
    ext_run = 1'b0;
    reg_write(scs_pkg::ADDR_OSCILLATOR_CONTROL, 8'h07);
    read_check(scs_pkg::ADDR_OSCILLATOR_CONTROL);
    wait_open(1'b1);
    reg_write(scs_pkg::ADDR_OSCILLATOR_CONTROL, 8'h03);
    ext_man <= 1'b1;
    wait_open(1'b0);
    ext_man <= 1'b0;
    wait_open(1'b1);
    // force-on off without pin gating leaves the output gated but powered
    reg_write(scs_pkg::ADDR_OSCILLATOR_CONTROL, 8'h02);
    wait_open(1'b0);
    check("osc power", {7'h00, o_osc_power}, 8'h01);
    reg_write(scs_pkg::ADDR_OSCILLATOR_CONTROL, 8'h00);
    @(posedge i_clk);
    #1;
    check("osc power", {7'h00, o_osc_power}, 8'h00);
    reg_write(scs_pkg::ADDR_OSCILLATOR_CONTROL, 8'h06);
    wait_open(1'b1);
    check("osc power", {7'h00, o_osc_power}, 8'h01);
    read_check(scs_pkg::ADDR_OSCILLATOR_CONTROL);
    print_verdict();
  end
endmodule
`default_nettype wire
